/* File: verilog/sadc_pkg.sv */
package sadc_pkg;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_NS       = 100;
    localparam int CONV_NS      = 500;
    localparam int CONV_DIV     = CONV_NS / CLK_NS;
    localparam int FILT_TICKS   = 2;
    localparam int CONV_MIN     = 26;
    localparam int CONV_MAX     = 32;
    localparam int SAMPLE_NS    = 1000;
    localparam int SAMPLE_CYC   = (SAMPLE_NS + CLK_NS - 1) / CLK_NS;
    localparam int CS_HOLD_NS   = 4 * CONV_NS;
    localparam int CS_HOLD_CYC  = (CS_HOLD_NS + CLK_NS - 1) / CLK_NS;
    localparam int CONV_WAIT_NS = (CONV_MAX + 2) * CONV_NS;
    localparam int CONV_WAIT_CYC = (CONV_WAIT_NS + CLK_NS - 1) / CLK_NS;
    localparam int SCLK_HALF    = 4;
    // ------------------------------------------------------------
    // framing and addresses
    // ------------------------------------------------------------
    localparam int XFER_BITS  = 8;
    localparam int ADDR_BITS  = 5;
    localparam logic [4:0] ADDR_HALF_SCALE = 5'h13;
    localparam logic [4:0] ADDR_NONE_FIRST = 5'h14;
    localparam logic [4:0] ADDR_TEST_FIRST = 5'h18;
    localparam logic [7:0] RESULT_RST      = 8'h00;
    localparam logic [7:0] HALF_SCALE_CODE = 8'h80;
    localparam logic [7:0] NO_CHANNEL_CODE = 8'h00;
    localparam logic [2:0] LFSR_SEED       = 3'h1;
    // ------------------------------------------------------------
    // states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {DS_IDLE, DS_XFER, DS_SAMPLE, DS_CONV} sadc_dev_e;
    typedef enum logic [1:0] {HS_IDLE, HS_SETUP, HS_SHIFT, HS_GAP} sadc_host_e;
endpackage : sadc_pkg

/* File: verilog/sadc_if.sv */
`timescale 1ns/100ps
interface sadc_if;
    logic cs_n;
    logic sclk;
    logic serial_address_in;
    logic dout;
    logic dout_oe;
    logic dout_level;
    // undriven data line rests high
    assign dout_level = dout_oe ? dout : 1'b1;
    modport dev (input cs_n, input sclk, input serial_address_in,
                 output dout, output dout_oe);
    modport host (output cs_n, output sclk, output serial_address_in,
                  input dout_level);
endinterface : sadc_if

/* File: verilog/sadc_device.sv */
`timescale 1ns/100ps
// Notes on behaviour
// - select fall recognised after one-two conversion periods
// - select pulses under one period ignored
// - host holds select low for 20 clocks before shifting
// - select fall drives previous result msb at once
// - address bits shift on the first five rising edges
// - five cycles address, three cycles sample
// - bits six to zero on falling edges
// - eighth fall starts 26-32 period conversion
// - select low: next exchange after conversion
// - host reselects after 34th conversion period
// - select high: output off, result kept
// - recognised strobe aborts, data invalid until conversion
// - gated clock stops 34 periods after exchange
// - select low: new msb after conversion
// - five-bit address msb first selects input
// - addresses 24 up enter logic test mode
// - sample 1 us after eighth fall, hold
// - result kept until read, read restarts
// - rise samples address, fall shifts result
module sadc_device
    import sadc_pkg::*;
#(
    parameter int CONV_DIV_P   = CONV_DIV,
    parameter int SAMPLE_CYC_P = SAMPLE_CYC
) (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       arst_n,
    input  wire logic       ce,
    // serial link
    sadc_if.dev             link,
    // analog front end
    input  wire logic [7:0] analog_code,
    output logic      [4:0] chan_sel_q,
    output logic            half_scale_test_input_q,
    output logic            chan_none_q,
    output logic            sampling_q,
    // conversion status
    output logic [7:0]      result_q,
    output logic            result_valid_q,
    output logic            conv_done_q,
    // production test mode
    output logic            test_mode_q,
    output logic [4:0]      test_out_q
);
    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic cs_s1_q, cs_s2_q;
    logic sclk_s1_q, sclk_s2_q, sclk_d_q;
    logic din_s1_q, din_s2_q;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cs_s1_q   <= 1'b1;
            cs_s2_q   <= 1'b1;
            sclk_s1_q <= 1'b0;
            sclk_s2_q <= 1'b0;
            sclk_d_q  <= 1'b0;
            din_s1_q  <= 1'b0;
            din_s2_q  <= 1'b0;
        end else if (ce) begin
            cs_s1_q   <= link.cs_n;
            cs_s2_q   <= cs_s1_q;
            sclk_s1_q <= link.sclk;
            sclk_s2_q <= sclk_s1_q;
            sclk_d_q  <= sclk_s2_q;
            din_s1_q  <= link.serial_address_in;
            din_s2_q  <= din_s1_q;
        end
    end
    // shift clock is ignored while select is high
    logic sclk_rise, sclk_fall;
    assign sclk_rise = sclk_s2_q & ~sclk_d_q & ~cs_s2_q;
    assign sclk_fall = ~sclk_s2_q & sclk_d_q & ~cs_s2_q;
    // ------------------------------------------------------------
    // conversion clock
    // ------------------------------------------------------------
    localparam int DW = $clog2(CONV_DIV_P + 1);
    logic [DW-1:0] div_q;
    logic          tick_q;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            div_q  <= '0;
            tick_q <= 1'b0;
        end else if (ce) begin
            if (div_q == DW'(CONV_DIV_P - 1)) begin
                div_q  <= '0;
                tick_q <= 1'b1;
            end else begin
                div_q  <= div_q + DW'(1);
                tick_q <= 1'b0;
            end
        end
    end
    // ------------------------------------------------------------
    // select filter
    // ------------------------------------------------------------
    logic       cs_f_q;
    logic [1:0] filt_q;
    logic       filt_hit;
    assign filt_hit = tick_q && (cs_s2_q != cs_f_q) && (filt_q == 2'(FILT_TICKS - 1));
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cs_f_q <= 1'b1;
            filt_q <= '0;
        end else if (ce) begin
            if (cs_s2_q == cs_f_q) begin
                filt_q <= '0;
            end else if (filt_hit) begin
                cs_f_q <= cs_s2_q;
                filt_q <= '0;
            end else if (tick_q) begin
                filt_q <= filt_q + 2'h1;
            end
        end
    end
    logic cs_rec_low, cs_rec_high;
    assign cs_rec_low  = filt_hit & ~cs_s2_q;
    assign cs_rec_high = filt_hit & cs_s2_q;
    // ------------------------------------------------------------
    // conversion length source
    // ------------------------------------------------------------
    logic [2:0] lfsr_q;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            lfsr_q <= LFSR_SEED;
        end else if (ce) begin
            lfsr_q <= {lfsr_q[1:0], lfsr_q[2] ^ lfsr_q[1]};
        end
    end
    // ------------------------------------------------------------
    // exchange and conversion sequencer
    // ------------------------------------------------------------
    sadc_dev_e   state_q;
    logic [3:0]  rise_q, fall_q;
    logic [4:0]  addr_sr_q;
    logic [7:0]  out_sr_q;
    logic [7:0]  held_q;
    logic [5:0]  conv_q, conv_len_q;
    logic [4:0]  samp_q;
    logic [4:0]  addr_now;
    logic [7:0]  code_now;
    assign addr_now = {addr_sr_q[3:0], din_s2_q};
    always_comb begin
        if (half_scale_test_input_q) begin
            code_now = HALF_SCALE_CODE;
        end else if (chan_none_q) begin
            code_now = NO_CHANNEL_CODE;
        end else begin
            code_now = analog_code;
        end
    end
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_q        <= DS_IDLE;
            rise_q         <= '0;
            fall_q         <= '0;
            addr_sr_q      <= '0;
            out_sr_q       <= RESULT_RST;
            held_q         <= RESULT_RST;
            result_q       <= RESULT_RST;
            result_valid_q <= 1'b0;
            conv_done_q    <= 1'b0;
            conv_q         <= '0;
            conv_len_q     <= 6'(CONV_MAX);
            samp_q         <= '0;
        end else if (ce) begin
            conv_done_q <= 1'b0;
            if (cs_rec_low) begin
                if (state_q != DS_IDLE) begin
                    result_valid_q <= 1'b0;
                end
                state_q  <= DS_XFER;
                rise_q   <= '0;
                fall_q   <= '0;
                out_sr_q <= result_q;
            end else if (cs_rec_high && state_q != DS_CONV && state_q != DS_SAMPLE) begin
                if (state_q != DS_IDLE) begin
                    result_valid_q <= 1'b0;
                end
                state_q <= DS_IDLE;
            end else begin
                case (state_q)
                    DS_XFER: begin
                        if (sclk_rise && rise_q < 4'(XFER_BITS)) begin
                            rise_q <= rise_q + 4'h1;
                            if (rise_q < 4'(ADDR_BITS)) begin
                                addr_sr_q <= addr_now;
                            end
                        end
                        if (sclk_fall) begin
                            fall_q <= fall_q + 4'h1;
                            if (fall_q == 4'(XFER_BITS - 1)) begin
                                state_q <= DS_SAMPLE;
                                samp_q  <= '0;
                            end else begin
                                out_sr_q <= {out_sr_q[6:0], 1'b0};
                            end
                        end
                    end
                    DS_SAMPLE: begin
                        if (samp_q == 5'(SAMPLE_CYC_P - 1)) begin
                            held_q     <= code_now;
                            state_q    <= DS_CONV;
                            conv_q     <= '0;
                            conv_len_q <= 6'(CONV_MIN - 1) + {3'h0, lfsr_q};
                        end else begin
                            samp_q <= samp_q + 5'h1;
                        end
                    end
                    DS_CONV: begin
                        if (tick_q) begin
                            conv_q <= conv_q + 6'h1;
                            if (conv_q == conv_len_q - 6'h1) begin
                                result_q       <= held_q;
                                result_valid_q <= 1'b1;
                                conv_done_q    <= 1'b1;
                                if (!cs_f_q) begin
                                    state_q  <= DS_XFER;
                                    rise_q   <= '0;
                                    fall_q   <= '0;
                                    out_sr_q <= held_q;
                                end else begin
                                    state_q <= DS_IDLE;
                                end
                            end
                        end
                    end
                    DS_IDLE: begin
                        rise_q   <= '0;
                        out_sr_q <= result_q;
                    end
                    default: begin
                        state_q <= DS_IDLE;
                    end
                endcase
            end
        end
    end
    // ------------------------------------------------------------
    // channel selection and sampling
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            chan_sel_q              <= '0;
            half_scale_test_input_q <= 1'b0;
            chan_none_q             <= 1'b0;
            test_mode_q             <= 1'b0;
            sampling_q              <= 1'b0;
        end else if (ce) begin
            if (state_q == DS_XFER && sclk_rise && rise_q == 4'(ADDR_BITS - 1)) begin
                chan_sel_q              <= addr_now;
                half_scale_test_input_q <= addr_now == ADDR_HALF_SCALE;
                chan_none_q             <= addr_now >= ADDR_NONE_FIRST
                                           && addr_now < ADDR_TEST_FIRST;
                test_mode_q             <= addr_now >= ADDR_TEST_FIRST;
                sampling_q              <= 1'b1;
            end else if (state_q == DS_SAMPLE && samp_q == 5'(SAMPLE_CYC_P - 1)) begin
                sampling_q <= 1'b0;
            end else if (state_q == DS_IDLE) begin
                sampling_q <= 1'b0;
            end
        end
    end
    // ------------------------------------------------------------
    // output pins
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            test_out_q <= '0;
        end else if (ce) begin
            test_out_q <= test_mode_q ? result_q[4:0] : 5'h00;
        end
    end
    // driver follows the synchronised select, ahead of the filter
    assign link.dout    = out_sr_q[7];
    assign link.dout_oe = ~cs_s2_q;
endmodule : sadc_device

/* File: verilog/sadc_host.sv */
`timescale 1ns/100ps
module sadc_host
    import sadc_pkg::*;
#(
    parameter int SCLK_HALF_P     = SCLK_HALF,
    parameter int CS_HOLD_CYC_P   = CS_HOLD_CYC,
    parameter int CONV_WAIT_CYC_P = CONV_WAIT_CYC
) (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       arst_n,
    input  wire logic       ce,
    // serial link
    sadc_if.host            link,
    // user request
    input  wire logic       start,
    input  wire logic [4:0] addr,
    input  wire logic       gated_mode,
    // user answer
    output logic            busy_q,
    output logic [7:0]      result_q,
    output logic            result_strobe_q,
    output logic            addr_err_q
);
    // ------------------------------------------------------------
    // data line synchroniser
    // ------------------------------------------------------------
    logic dout_s1_q, dout_s2_q;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            dout_s1_q <= 1'b1;
            dout_s2_q <= 1'b1;
        end else if (ce) begin
            dout_s1_q <= link.dout_level;
            dout_s2_q <= dout_s1_q;
        end
    end
    // ------------------------------------------------------------
    // exchange sequencer
    // ------------------------------------------------------------
    sadc_host_e state_q;
    logic [7:0] cnt_q;
    logic [3:0] bit_q;
    logic [7:0] tx_q, rx_q;
    logic       cs_n_q, sclk_q, mosi_q, gated_q;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_q         <= HS_IDLE;
            cnt_q           <= '0;
            bit_q           <= '0;
            tx_q            <= '0;
            rx_q            <= '0;
            cs_n_q          <= 1'b1;
            sclk_q          <= 1'b0;
            mosi_q          <= 1'b0;
            gated_q         <= 1'b0;
            busy_q          <= 1'b0;
            result_q        <= RESULT_RST;
            result_strobe_q <= 1'b0;
            addr_err_q      <= 1'b0;
        end else if (ce) begin
            result_strobe_q <= 1'b0;
            addr_err_q      <= 1'b0;
            case (state_q)
                HS_IDLE: begin
                    if (start && addr >= ADDR_TEST_FIRST) begin
                        addr_err_q <= 1'b1;
                    end else if (start) begin
                        busy_q  <= 1'b1;
                        gated_q <= gated_mode;
                        tx_q    <= {addr, 3'h0};
                        mosi_q  <= addr[4];
                        cnt_q   <= '0;
                        bit_q   <= '0;
                        if (cs_n_q) begin
                            cs_n_q  <= 1'b0;
                            state_q <= HS_SETUP;
                        end else begin
                            state_q <= HS_SHIFT;
                        end
                    end else if (!gated_mode) begin
                        cs_n_q <= 1'b1;
                    end
                end
                HS_SETUP: begin
                    if (cnt_q == 8'(CS_HOLD_CYC_P - 1)) begin
                        cnt_q   <= '0;
                        state_q <= HS_SHIFT;
                    end else begin
                        cnt_q <= cnt_q + 8'h1;
                    end
                end
                HS_SHIFT: begin
                    if (cnt_q == 8'(SCLK_HALF_P - 1)) begin
                        cnt_q  <= '0;
                        sclk_q <= ~sclk_q;
                        if (sclk_q) begin
                            rx_q  <= {rx_q[6:0], dout_s2_q};
                            tx_q  <= {tx_q[6:0], 1'b0};
                            mosi_q <= tx_q[6];
                            bit_q <= bit_q + 4'h1;
                            if (bit_q == 4'(XFER_BITS - 1)) begin
                                state_q         <= HS_GAP;
                                result_q        <= {rx_q[6:0], dout_s2_q};
                                result_strobe_q <= 1'b1;
                            end
                        end
                    end else begin
                        cnt_q <= cnt_q + 8'h1;
                    end
                end
                HS_GAP: begin
                    // outside gated mode, select rises half a shift period after the last fall
                    if (!gated_q && cnt_q == 8'(SCLK_HALF_P - 1)) begin
                        cs_n_q <= 1'b1;
                    end
                    if (cnt_q == 8'(CONV_WAIT_CYC_P - 1)) begin
                        cnt_q   <= '0;
                        busy_q  <= 1'b0;
                        state_q <= HS_IDLE;
                    end else begin
                        cnt_q <= cnt_q + 8'h1;
                    end
                end
                default: begin
                    state_q <= HS_IDLE;
                end
            endcase
        end
    end
    assign link.cs_n              = cs_n_q;
    assign link.sclk              = sclk_q;
    assign link.serial_address_in = mosi_q;
endmodule : sadc_host

/* File: tb/sadc_props.sv */
`timescale 1ns/100ps
module sadc_props (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // link
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic serial_address_in,
    input wire logic dout,
    input wire logic dout_oe
);
    logic       sclk_q;
    logic       cs_q;
    logic [7:0] low_q;
    logic [2:0] fall_q;
    logic       gap_q;
    logic [3:0] rise_q;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    // ------------------------------------------------------------
    // helper counters
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sclk_q <= 1'b0;
            cs_q   <= 1'b1;
        end else begin
            sclk_q <= sclk;
            cs_q   <= cs_n;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            low_q <= 8'h00;
        end else if (sclk) begin
            low_q <= 8'h00;
        end else if (low_q != 8'hff) begin
            low_q <= low_q + 8'h01;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            fall_q <= 3'h0;
            gap_q  <= 1'b0;
        end else if (sclk_q && !sclk) begin
            fall_q <= fall_q + 3'h1;
            gap_q  <= (fall_q == 3'h7);
        end else if (sclk && !sclk_q) begin
            gap_q  <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rise_q <= 4'h0;
        end else if (cs_q && !cs_n) begin
            rise_q <= 4'h0;
        end else if (sclk && !sclk_q) begin
            rise_q <= rise_q + 4'h1;
        end
    end

    // ------------------------------------------------------------
    // link assertions
    // ------------------------------------------------------------
    oe_on_a: assert property ($fell(cs_n) |-> ##[1:2] dout_oe)
        else $error("data line not driven after select fall");
    oe_held_a: assert property ((!cs_n)[*3] |-> dout_oe)
        else $error("data line released while selected");
    oe_off_a: assert property (cs_n[*3] |-> !dout_oe)
        else $error("data line driven while deselected");
    sclk_cs_a: assert property ($rose(sclk) |-> !cs_n)
        else $error("shift clock rose while deselected");
    bits_eight_a: assert property ($rose(cs_n) |-> rise_q == 4'h8)
        else $error("exchange did not hold eight shift clocks");
    setup_gap_a: assert property ($fell(cs_n) |=> (!sclk)[*8])
        else $error("shift clock too soon after select fall");
    addr_stable_a: assert property (sclk && $past(sclk) |-> $stable(serial_address_in))
        else $error("address bit changed while shift clock high");
    gated_gap_a: assert property ($rose(sclk) && gap_q |-> low_q >= 8'ha0)
        else $error("shift clock resumed before conversion time");
endmodule : sadc_props

/* File: tb/testbench.sv */
`timescale 1ns/100ps
module testbench;
    import sadc_pkg::*;
    logic clk = 1'b0, arst_n = 1'b0, start = 1'b0, gated = 1'b0;
    logic [4:0] addr = 5'h00;
    logic [7:0] code = 8'ha5;
    logic [4:0] chan_sel, tout;
    logic [7:0] dres, hres;
    logic half, none, sampling, dvalid, done, tmode, busy, hstrobe, aerr;
    int mismatches = 0, n_compared = 0, cycles = 0, n;

    sadc_if i_sadc_if ();
    sadc_device i_sadc_device (.clk(clk), .arst_n(arst_n), .ce(1'b1), .link(i_sadc_if),
        .analog_code(code), .chan_sel_q(chan_sel), .half_scale_test_input_q(half),
        .chan_none_q(none), .sampling_q(sampling), .result_q(dres), .result_valid_q(dvalid),
        .conv_done_q(done), .test_mode_q(tmode), .test_out_q(tout));
    sadc_host i_sadc_host (.clk(clk), .arst_n(arst_n), .ce(1'b1), .link(i_sadc_if),
        .start(start), .addr(addr), .gated_mode(gated), .busy_q(busy), .result_q(hres),
        .result_strobe_q(hstrobe), .addr_err_q(aerr));
    sadc_props i_sadc_props (.clk(clk), .arst_n(arst_n), .cs_n(i_sadc_if.cs_n),
        .sclk(i_sadc_if.sclk), .serial_address_in(i_sadc_if.serial_address_in),
        .dout(i_sadc_if.dout), .dout_oe(i_sadc_if.dout_oe));

    // ------------------------------------------------------------
    // clock, timeout, report
    // ------------------------------------------------------------
    initial begin
        forever #50 clk = ~clk;
    end

    task check(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task complete_run;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : complete_run

    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            complete_run();
        end
    end

    // ------------------------------------------------------------
    // exchange tasks
    // ------------------------------------------------------------
    task pulse_start(input logic [4:0] a);
        @(posedge clk);
        #1 start = 1'b1;
        addr = a;
        @(posedge clk);
        #1 start = 1'b0;
    endtask : pulse_start

    task xfer(input logic [4:0] a, input logic [7:0] exp);
        pulse_start(a);
        n = 0;
        while (hstrobe !== 1'b1 && n < 400) begin
            @(posedge clk);
            #1 n++;
        end
        check(hres, exp);
        n = 0;
        while (done !== 1'b1 && n < 400) begin
            @(posedge clk);
            #1 n++;
        end
        check({7'h00, done}, 8'h01);
        n = 0;
        while (busy !== 1'b0 && n < 400) begin
            @(posedge clk);
            #1 n++;
        end
        check({7'h00, busy}, 8'h00);
    endtask : xfer

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        repeat (5) @(posedge clk);
        #1 arst_n = 1'b1;
        repeat (20) @(posedge clk);
        xfer(5'h03, RESULT_RST);
        check(dres, 8'ha5);
        check({7'h00, dvalid}, 8'h01);
        check({3'h0, chan_sel}, 8'h03);
        check({7'h00, sampling}, 8'h00);
        $display("test continuous done");
        xfer(ADDR_HALF_SCALE, 8'ha5);
        check({7'h00, half}, 8'h01);
        check(dres, HALF_SCALE_CODE);
        xfer(5'h15, HALF_SCALE_CODE);
        check({7'h00, none}, 8'h01);
        check(dres, NO_CHANNEL_CODE);
        $display("test channel decode done");
        pulse_start(ADDR_TEST_FIRST);
        n = 0;
        while (aerr !== 1'b1 && n < 3) begin
            @(posedge clk);
            #1 n++;
        end
        check({7'h00, aerr}, 8'h01);
        repeat (30) @(posedge clk);
        #1 check({7'h00, i_sadc_if.cs_n}, 8'h01);
        check({7'h00, tmode}, 8'h00);
        check({3'h0, tout}, 8'h00);
        $display("test address guard done");
        gated = 1'b1;
        code = 8'h3c;
        xfer(5'h07, NO_CHANNEL_CODE);
        check({7'h00, i_sadc_if.cs_n}, 8'h00);
        xfer(5'h12, 8'h3c);
        xfer(5'h12, 8'h3c);
        check({3'h0, chan_sel}, 8'h12);
        $display("test gated done");
        complete_run();
    end
endmodule : testbench
